// file: node_filter_pkg.sv
package node_filter_pkg;

    localparam int unsigned DATA_W     = 32;
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned NODE_W     = 6;
    localparam int unsigned BUS_W      = 10;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] UPPER_SET_ADDR  = 12'h000;
    localparam logic [ADDR_W-1:0] UPPER_CLR_ADDR  = 12'h004;
    localparam logic [ADDR_W-1:0] LOWER_SET_ADDR  = 12'h008;
    localparam logic [ADDR_W-1:0] LOWER_CLR_ADDR  = 12'h00C;
    localparam logic [ADDR_W-1:0] STATUS_ADDR     = 12'h010;

    localparam logic [DATA_W-1:0] MASK_RESET      = 32'h00000000;
    localparam logic [DATA_W-1:0] ZERO_WORD       = 32'h00000000;

    // Upper register fields
    localparam int unsigned REMOTE_BUS_BIT  = 31;
    localparam int unsigned UPPER_NODE_BASE = 32;
    localparam logic [NODE_W-1:0] UPPER_NODE_MAX = 6'h3E;

    // Status register fields
    localparam int unsigned STAT_ACCEPT_BIT = 0;
    localparam int unsigned STAT_ACK_BIT    = 1;
    localparam int unsigned STAT_CNT_LSB    = 16;
    localparam int unsigned DROP_CNT_W      = 16;

    typedef enum logic [1:0] {
        CTX_OTHER,
        CTX_PHYSICAL,
        CTX_ASYNC_RECEIVE
    } dest_ctx_e;

endpackage

// file: set_clear_mask.sv
`timescale 1ns/1ps
module set_clear_mask
    import node_filter_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              set_en,
    input  wire logic              clr_en,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] mask
);

    logic [DATA_W-1:0] mask_reg;
    logic [DATA_W-1:0] mask_next;

    // Ones set or clear, zeros leave bits alone
    always_comb begin
        mask_next = mask_reg;
        if (set_en) begin
            mask_next = mask_reg | wdata;
        end else if (clr_en) begin
            mask_next = mask_reg & ~wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= MASK_RESET;
        end else begin
            mask_reg <= mask_next;
        end
    end

    assign mask = mask_reg;

endmodule

// file: async_request_node_filter.sv
// Functional notes
// - Requests for physical or async receive context are checked against source node.
// - Disabled source node: request is neither acknowledged nor queued.
// - Per-node bit check applies only to sources on our own bus.
// - Remote-bus requests accepted only when upper register bit 31 is set.
// - Upper register bit k enables local node 32 plus k, k up to 30.
// - Upper register covers high node ids, written via set and clear addresses.
// - Lower register gates like upper, for its own node range, but all 32 of its bits are node enables.
// - Lower register bit n enables local node n, n from 0 to 31.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module async_request_node_filter
    import node_filter_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [BUS_W-1:0]  local_bus_id,
    input  wire logic              req_valid,
    input  wire logic [BUS_W-1:0]  req_src_bus,
    input  wire logic [NODE_W-1:0] req_src_node,
    input  wire dest_ctx_e         req_dest_ctx,
    output logic                   decision_valid,
    output logic                   decision_ack,
    output logic                   decision_queue
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register access decode

    logic              access;
    logic              setup;
    logic              mapped;
    logic              hit_upper;
    logic              hit_lower;
    logic              hit_status;
    logic              upper_set_en;
    logic              upper_clr_en;
    logic              lower_set_en;
    logic              lower_clr_en;
    logic [DATA_W-1:0] upper_mask;
    logic [DATA_W-1:0] lower_mask;

    assign access = psel & penable;
    assign setup  = psel & ~penable;

    // One decoder feeds the error flag and the read mux alike
    always_comb begin
        hit_upper  = 1'b0;
        hit_lower  = 1'b0;
        hit_status = 1'b0;
        case (paddr)
            UPPER_SET_ADDR, UPPER_CLR_ADDR: begin
                hit_upper = 1'b1;
            end
            LOWER_SET_ADDR, LOWER_CLR_ADDR: begin
                hit_lower = 1'b1;
            end
            STATUS_ADDR: begin
                hit_status = 1'b1;
            end
            default: begin
                hit_status = 1'b0;
            end
        endcase
    end

    assign mapped = hit_upper | hit_lower | hit_status;

    // Zero wait states: read data is captured during setup
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    assign upper_set_en = access & pwrite & (paddr == UPPER_SET_ADDR);
    assign upper_clr_en = access & pwrite & (paddr == UPPER_CLR_ADDR);
    assign lower_set_en = access & pwrite & (paddr == LOWER_SET_ADDR);
    assign lower_clr_en = access & pwrite & (paddr == LOWER_CLR_ADDR);

    set_clear_mask u_upper (
        .pclk    (pclk),
        .presetn (presetn),
        .set_en  (upper_set_en),
        .clr_en  (upper_clr_en),
        .wdata   (pwdata),
        .mask    (upper_mask)
    );

    set_clear_mask u_lower (
        .pclk    (pclk),
        .presetn (presetn),
        .set_en  (lower_set_en),
        .clr_en  (lower_clr_en),
        .wdata   (pwdata),
        .mask    (lower_mask)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Request decision

    logic                  filtered_ctx;
    logic                  same_bus;
    logic                  node_bit;
    logic [2*DATA_W-1:0]   node_enable;
    logic                  accept;
    logic                  decision_valid_reg;
    logic                  decision_valid_next;
    logic                  decision_ack_reg;
    logic                  decision_ack_next;
    logic                  last_accept_reg;
    logic                  last_accept_next;
    logic                  last_ack_reg;
    logic                  last_ack_next;
    logic [DROP_CNT_W-1:0] drop_cnt_reg;
    logic [DROP_CNT_W-1:0] drop_cnt_next;
    logic [DATA_W-1:0]     prdata_reg;
    logic [DATA_W-1:0]     prdata_next;

    assign filtered_ctx = (req_dest_ctx == CTX_PHYSICAL) ||
                          (req_dest_ctx == CTX_ASYNC_RECEIVE);
    assign same_bus     = (req_src_bus == local_bus_id);

    // Node 63 has no enable bit, so it never passes the per-node check
    generate
        for (genvar g = 0; g < DATA_W; g++) begin : g_node
            assign node_enable[g] = lower_mask[g];
            if (g == REMOTE_BUS_BIT) begin : g_top
                assign node_enable[UPPER_NODE_BASE + g] = 1'b0;
            end else begin : g_high
                assign node_enable[UPPER_NODE_BASE + g] = upper_mask[g];
            end
        end
    endgenerate

    assign node_bit = node_enable[req_src_node];

    always_comb begin
        if (!filtered_ctx) begin
            accept = 1'b1;
        end else if (same_bus) begin
            accept = node_bit;
        end else begin
            accept = upper_mask[REMOTE_BUS_BIT];
        end
    end

    always_comb begin
        decision_valid_next = req_valid;
        decision_ack_next   = decision_ack_reg;
        if (req_valid) begin
            decision_ack_next = accept;
        end
    end

    always_comb begin
        last_accept_next = last_accept_reg;
        last_ack_next    = last_ack_reg;
        drop_cnt_next    = drop_cnt_reg;
        if (req_valid) begin
            last_accept_next = accept;
            last_ack_next    = accept;
            // Saturate so software never sees a wrapped small count
            if (!accept && (drop_cnt_reg != {DROP_CNT_W{1'b1}})) begin
                drop_cnt_next = drop_cnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb begin
        prdata_next = prdata_reg;
        if (setup) begin
            prdata_next = ZERO_WORD;
            if (!pwrite) begin
                if (hit_upper) begin
                    prdata_next = upper_mask;
                end else if (hit_lower) begin
                    prdata_next = lower_mask;
                end else if (hit_status) begin
                    prdata_next[STAT_ACCEPT_BIT] = last_accept_reg;
                    prdata_next[STAT_ACK_BIT]    = last_ack_reg;
                    prdata_next[STAT_CNT_LSB +: DROP_CNT_W] = drop_cnt_reg;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decision_valid_reg <= 1'b0;
            decision_ack_reg   <= 1'b0;
        end else begin
            decision_valid_reg <= decision_valid_next;
            decision_ack_reg   <= decision_ack_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_accept_reg <= 1'b0;
            last_ack_reg    <= 1'b0;
            drop_cnt_reg    <= '0;
        end else begin
            last_accept_reg <= last_accept_next;
            last_ack_reg    <= last_ack_next;
            drop_cnt_reg    <= drop_cnt_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= ZERO_WORD;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    assign decision_valid = decision_valid_reg;
    assign decision_ack   = decision_ack_reg;
    // A rejected request must not be queued either
    assign decision_queue = decision_ack_reg;
    assign prdata         = prdata_reg;

endmodule

// file: node_filter_chk.sv
`timescale 1ns/1ps
module node_filter_chk
    import node_filter_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic [BUS_W-1:0]  local_bus_id,
    input wire logic              req_valid,
    input wire logic [BUS_W-1:0]  req_src_bus,
    input wire logic [NODE_W-1:0] req_src_node,
    input wire dest_ctx_e         req_dest_ctx,
    input wire logic              decision_valid,
    input wire logic              decision_ack,
    input wire logic              decision_queue
);
    logic [31:0] lo_reg, hi_reg, lo_next, hi_next;
    wire filt = req_valid && (req_dest_ctx == CTX_PHYSICAL || req_dest_ctx == CTX_ASYNC_RECEIVE);
    wire loc = req_src_bus == local_bus_id;
    wire lo_hit = lo_reg[req_src_node[4:0]];
    wire hi_hit = hi_reg[req_src_node[4:0]];
    wire all_bus = hi_reg[REMOTE_BUS_BIT];
    wire node_hit = req_src_node[5] ? ((req_src_node != 6'h3F) && hi_hit) : lo_hit;
    wire exp_ok = !filt || (loc ? node_hit : all_bus);
    always_comb begin
        lo_next = lo_reg;
        hi_next = hi_reg;
        if (psel && penable && pwrite) begin
            if (paddr == UPPER_SET_ADDR) hi_next = hi_reg | pwdata;
            if (paddr == UPPER_CLR_ADDR) hi_next = hi_reg & ~pwdata;
            if (paddr == LOWER_SET_ADDR) lo_next = lo_reg | pwdata;
            if (paddr == LOWER_CLR_ADDR) lo_next = lo_reg & ~pwdata;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_reg <= MASK_RESET;
            hi_reg <= MASK_RESET;
        end else begin
            lo_reg <= lo_next;
            hi_reg <= hi_next;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_valid; req_valid |=> decision_valid; endproperty
    a_valid: assert property (p_valid) else $error("no decision");
    property p_oth; req_valid && req_dest_ctx == CTX_OTHER |=> decision_ack; endproperty
    a_oth: assert property (p_oth) else $error("bypass dropped");
    property p_q; req_valid |=> decision_queue == $past(exp_ok); endproperty
    a_q: assert property (p_q) else $error("queue verdict wrong");
    property p_bc; filt && loc && req_src_node == 6'h3F |=> !decision_ack; endproperty
    a_bc: assert property (p_bc) else $error("node 63 taken");
    property p_rm; filt && !loc |=> decision_ack == $past(all_bus); endproperty
    a_rm: assert property (p_rm) else $error("remote bus wrong");
    property p_hi; filt && loc && req_src_node[5] && req_src_node != 6'h3F
        |=> decision_ack == $past(hi_hit); endproperty
    a_hi: assert property (p_hi) else $error("upper node wrong");
    property p_lo; filt && loc && !req_src_node[5] |=> decision_ack == $past(lo_hit); endproperty
    a_lo: assert property (p_lo) else $error("lower node wrong");
    property p_rd; psel && penable && !pwrite && paddr == LOWER_SET_ADDR |-> prdata == lo_reg;
    endproperty
    a_rd: assert property (p_rd) else $error("mask readback wrong");
endmodule
bind async_request_node_filter node_filter_chk u_chk (.*);

// file: node_sender.sv
`timescale 1ns/1ps
module node_sender
    import node_filter_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              fire,
    input  wire logic [BUS_W-1:0]  bus,
    input  wire logic [NODE_W-1:0] node,
    input  wire dest_ctx_e         ctx,
    output logic                   req_valid,
    output logic      [BUS_W-1:0]  req_src_bus,
    output logic      [NODE_W-1:0] req_src_node,
    output dest_ctx_e              req_dest_ctx
);
    // Idle header toggles, so a stale one never passes for valid
    initial begin
        req_valid = 1'b0;
        req_src_bus = 10'h000;
        req_src_node = 6'h00;
        req_dest_ctx = CTX_OTHER;
    end
    always @(posedge pclk) begin
        req_valid <= fire;
        req_src_bus <= fire ? bus : ~req_src_bus;
        req_src_node <= fire ? node : ~req_src_node;
        req_dest_ctx <= fire ? ctx : dest_ctx_e'(~req_dest_ctx);
    end
endmodule

// file: async_request_node_filter_tb.sv
`timescale 1ns/1ps
module async_request_node_filter_tb;
    import node_filter_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [DATA_W-1:0] pwdata = 32'h0, prdata, lo_m = 32'h0, hi_m = 32'h0;
    logic [BUS_W-1:0] local_bus_id = 10'h000, bus = 10'h000, req_src_bus;
    logic [NODE_W-1:0] node = 6'h00, req_src_node;
    dest_ctx_e ctx = CTX_OTHER, req_dest_ctx;
    logic pready, pslverr, req_valid, decision_valid, decision_ack, decision_queue;
    logic [31:0] q[$], r[$];
    int err_count = 0, tests_run = 0, n;
    int drop_n = 0;
    logic [31:0] exp_v, last_e = 32'h0;
    async_request_node_filter dut (.*);
    node_sender peer (.*);
    always #2.5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////
    task check(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task report_and_stop;
        if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function logic [31:0] e_ack(logic [9:0] b, logic [5:0] nd, dest_ctx_e c);
        if (c == CTX_OTHER) return 1;
        if (b !== local_bus_id) return hi_m[31];
        if (nd == 6'h3F) return 0;
        return nd[5] ? hi_m[nd[4:0]] : lo_m[nd[4:0]];
    endfunction
    always @(posedge pclk) begin
        if (decision_valid) begin
            exp_v = q.size() ? q.pop_front() : 2;
            check({31'h0, decision_ack}, exp_v);
            check({31'h0, decision_queue}, exp_v);
        end
        if (psel && penable && !pwrite) check(prdata, r.pop_front());
    end
    // Master allows wait states; bounded wait of up to 16 cycles on pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) r.push_back(e);
        @(posedge pclk) penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (!pready && n < 16);
        if (!pready) begin err_count++; report_and_stop(); end
        check({31'h0, pslverr}, {31'h0, a > STATUS_ADDR});
        if (w && a == UPPER_SET_ADDR) hi_m |= d;
        if (w && a == UPPER_CLR_ADDR) hi_m &= ~d;
        if (w && a == LOWER_SET_ADDR) lo_m |= d;
        if (w && a == LOWER_CLR_ADDR) lo_m &= ~d;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task burst(input int cnt);
        logic [9:0] b;
        logic [5:0] nd;
        dest_ctx_e c;
        for (int j = 0; j < cnt; j++) begin
            b = ($urandom % 2) ? local_bus_id : 10'($urandom);
            nd = 6'($urandom);
            c = dest_ctx_e'($urandom % 3);
            // Node 63 on our own bus is rare at random, so force it once
            if (j == 0) begin
                b = local_bus_id;
                nd = 6'h3F;
                c = CTX_ASYNC_RECEIVE;
            end
            bus <= b;
            node <= nd;
            ctx <= c;
            fire <= 1;
            last_e = e_ack(b, nd, c);
            drop_n += (last_e == 0);
            q.push_back(last_e);
            @(posedge pclk);
        end
        fire <= 0;
        repeat (4) @(posedge pclk);
        check(q.size(), 0);
    endtask
    initial begin
        void'($urandom(87781));
        local_bus_id <= 10'($urandom);
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) apb(0, 12'(4 * i), 0, 0);
        for (int k = 0; k < 6; k++) begin
            burst(60);
            apb(1, UPPER_SET_ADDR, $urandom, 0);
            apb(1, LOWER_SET_ADDR, $urandom, 0);
            apb(1, UPPER_CLR_ADDR, $urandom, 0);
            apb(1, LOWER_CLR_ADDR, $urandom, 0);
            apb(1, STATUS_ADDR, 32'hFFFFFFFF, 0);
            apb(0, STATUS_ADDR, 0, {drop_n[15:0], 14'h0, last_e[0], last_e[0]});
            apb(0, UPPER_CLR_ADDR, 0, hi_m);
            apb(0, LOWER_SET_ADDR, 0, lo_m);
        end
        report_and_stop();
    end
endmodule
